// *** core/ide_decoder.sv ***
// Instruction decoder and effective-address generator fed from the prefetch queue
`timescale 1ns/1ps
`default_nettype none
// Function
// - Add: 000000dw 3/10, 100000sw field 000 4/16, 0000010w 3/4.
// - Add with carry: 000100dw 3/10, 100000sw field 010 4/16, 0001010w 3/4.
// - Subtract: 100000sw field 101 4/16, 0010110w 3/4, reg/mem 3/10.
// - Subtract with borrow: 100000sw field 011 4/16, 0001110w 3/4.
// - Increment: 1111111w field 000 3/15, or 01000rrr in 3 clocks.
// - Decrement: 1111111w field 001 3/15, or 01001rrr in 3 clocks.
// - Compare immediate: 100000sw field 111 3/10, 0011110w 3/4.
// - Compare reg/mem forms 0011100w and 0011101w, 3/10 clocks.
// - Negate: 1111011w field 011, 3 register or 10 memory.
// - ASCII adjust add 00110111 8 clocks, subtract 00111111 7 clocks.
// - Decimal adjust 00100111 and 00101111, 4 clocks each.
// - Multiply 1111011w field 100: 26-28, 35-37, 32-34, 41-43 clocks.
// - Segment prefix 001ss110 selects a segment, 2 clocks.
// - Addressing form 11 makes operand-select a register number.
// - Form 00: no displacement, except select 110 takes a direct address.
// - Form 01: one displacement byte sign-extended to 16 bits.
// - Form 10: low then high displacement byte, 16-bit offset.
// - Operand-select picks base/frame and index register sums plus displacement.
// - Displacement bytes follow the second byte, ahead of immediate data.
// - Address computation takes 4 clocks, included in listed counts.
// - Memory instructions may take one or two clocks beyond minimum.
// - Jump and call counts include fetching the next opcode.
// - Register numbers map to word or byte registers by the size bit.
// - Frame-pointer addressed operands default to the stack segment.
// - String destinations use the extra segment, no override.
module ide_decoder
  import ide_pkg::*;
(
  input  wire logic                    mclk_in,
  input  wire logic                    rst_b_in,
  input  wire logic                    q_valid_in,
  input  wire logic [7:0]              q_byte_in,
  input  wire ide_pkg::ide_addr_regs_t addr_regs_in,
  input  wire logic                    string_dst_in,
  output logic                         q_ready_out,
  output logic                         dec_valid_out,
  output ide_pkg::ide_decode_t         dec_out,
  output logic                         dec_illegal_out
);
  import ide_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] sext8(input logic [7:0] b);
    sext8 = {{8{b[7]}}, b};
  endfunction

  // Register or memory clock pair selection
  function automatic logic [5:0] pick(input logic mem, input logic [5:0] r,
                                      input logic [5:0] m);
    pick = mem ? m : r;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  ide_state_t  state_reg, state_next;
  logic [7:0]  opc_reg;
  logic [7:0]  modrm_reg;
  logic [15:0] disp_reg;
  logic [15:0] imm_reg;
  logic [1:0]  seg_ovr_reg;
  logic        seg_ovr_vld_reg;
  logic        need_modrm, need_imm, imm_two, illegal;
  ide_op_t     op_d;
  logic        take;

  assign q_ready_out = 1'b1;
  assign take        = q_valid_in;

  // Opcode-level decode of the first byte
  always_comb begin
    logic [7:0] b;
    b          = (state_reg == IDE_ST_OPC) ? q_byte_in : opc_reg;
    op_d       = IDE_OP_NONE;
    need_modrm = 1'b0;
    need_imm   = 1'b0;
    imm_two    = 1'b0;
    illegal    = 1'b0;
    if (b[7:2] == IDE_PAT_ADD_RM) begin op_d = IDE_OP_ADD; need_modrm = 1'b1; end
    else if (b[7:2] == IDE_PAT_ADC_RM) begin op_d = IDE_OP_ADC; need_modrm = 1'b1; end
    else if (b[7:2] == IDE_PAT_SUB_RM) begin op_d = IDE_OP_SUB; need_modrm = 1'b1; end
    else if (b[7:2] == IDE_PAT_SBB_RM) begin op_d = IDE_OP_SBB; need_modrm = 1'b1; end
    else if (b[7:1] == IDE_PAT_CMP_RR || b[7:1] == IDE_PAT_CMP_MR) begin
      op_d = IDE_OP_CMP;
      need_modrm = 1'b1;
    end
    else if (b[7:2] == IDE_PAT_GRP1) begin
      need_modrm = 1'b1;
      need_imm   = 1'b1;
      imm_two    = (b[1:0] == 2'b01);
    end
    else if (b[7:1] == IDE_PAT_GRP4 || b[7:1] == IDE_PAT_GRP3) begin
      need_modrm = 1'b1;
    end
    else if (b[7:1] == IDE_PAT_ADD_AI) begin op_d = IDE_OP_ADD; need_imm = 1'b1; imm_two = b[0]; end
    else if (b[7:1] == IDE_PAT_ADC_AI) begin op_d = IDE_OP_ADC; need_imm = 1'b1; imm_two = b[0]; end
    else if (b[7:1] == IDE_PAT_SUB_AI) begin op_d = IDE_OP_SUB; need_imm = 1'b1; imm_two = b[0]; end
    else if (b[7:1] == IDE_PAT_SBB_AI) begin op_d = IDE_OP_SBB; need_imm = 1'b1; imm_two = b[0]; end
    else if (b[7:1] == IDE_PAT_CMP_AI) begin op_d = IDE_OP_CMP; need_imm = 1'b1; imm_two = b[0]; end
    else if (b[7:3] == IDE_PAT_INC_R) op_d = IDE_OP_INC;
    else if (b[7:3] == IDE_PAT_DEC_R) op_d = IDE_OP_DEC;
    else if (b == IDE_OPC_AAA) op_d = IDE_OP_AAA;
    else if (b == IDE_OPC_AAS) op_d = IDE_OP_AAS;
    else if (b == IDE_OPC_DAA) op_d = IDE_OP_DAA;
    else if (b == IDE_OPC_DAS) op_d = IDE_OP_DAS;
    else if (b[7:5] == IDE_SEG_HI && b[2:0] == IDE_SEG_LO) op_d = IDE_OP_SEG;
    else illegal = 1'b1; // Jumps and calls are not decoded
  end

  // Second-byte field and displacement length
  logic [1:0] mod_f;
  logic [2:0] xf, rm_f;
  logic       dlo_need, dhi_need;
  logic [7:0] mb;
  assign mb       = (state_reg == IDE_ST_MODRM) ? q_byte_in : modrm_reg;
  assign mod_f    = mb[7:6];
  assign xf       = mb[5:3];
  assign rm_f     = mb[2:0];
  // Displacement bytes precede any immediate bytes
  assign dlo_need = (mod_f == IDE_MOD_DISP8) || (mod_f == IDE_MOD_DISP16) ||
                    (mod_f == IDE_MOD_NODISP && rm_f == IDE_RM_DIRECT);
  assign dhi_need = (mod_f == IDE_MOD_DISP16) ||
                    (mod_f == IDE_MOD_NODISP && rm_f == IDE_RM_DIRECT);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  logic done;
  always_comb begin
    state_next = state_reg;
    done       = 1'b0;
    if (take) begin
      case (state_reg)
        IDE_ST_OPC: begin
          if (op_d == IDE_OP_SEG || illegal) state_next = IDE_ST_OPC;
          else if (need_modrm) state_next = IDE_ST_MODRM;
          else if (need_imm) state_next = IDE_ST_ILO;
          else done = 1'b1;
        end
        IDE_ST_MODRM: begin
          if (dlo_need) state_next = IDE_ST_DLO;
          else if (need_imm) state_next = IDE_ST_ILO;
          else begin state_next = IDE_ST_OPC; done = 1'b1; end
        end
        IDE_ST_DLO: begin
          if (dhi_need) state_next = IDE_ST_DHI;
          else if (need_imm) state_next = IDE_ST_ILO;
          else begin state_next = IDE_ST_OPC; done = 1'b1; end
        end
        IDE_ST_DHI: begin
          if (need_imm) state_next = IDE_ST_ILO;
          else begin state_next = IDE_ST_OPC; done = 1'b1; end
        end
        IDE_ST_ILO: begin
          if (imm_two) state_next = IDE_ST_IHI;
          else begin state_next = IDE_ST_OPC; done = 1'b1; end
        end
        IDE_ST_IHI: begin state_next = IDE_ST_OPC; done = 1'b1; end
        default: state_next = IDE_ST_OPC;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) state_reg <= IDE_ST_OPC;
    else state_reg <= state_next;
  end

  // Captured bytes
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      opc_reg   <= 8'h00;
      modrm_reg <= 8'h00;
      disp_reg  <= 16'h0000;
      imm_reg   <= 16'h0000;
    end else if (take) begin
      case (state_reg)
        IDE_ST_OPC: begin
          opc_reg   <= q_byte_in;
          modrm_reg <= 8'h00;
          disp_reg  <= 16'h0000;
          imm_reg   <= 16'h0000;
        end
        IDE_ST_MODRM: modrm_reg <= q_byte_in;
        IDE_ST_DLO:   disp_reg <= sext8(q_byte_in);
        IDE_ST_DHI:   disp_reg <= {q_byte_in, disp_reg[7:0]};
        IDE_ST_ILO: begin
          // Narrow immediate is sign-extended for sw=11 only; unsigned bytes stay zero-extended
          if (opc_reg[7:2] == IDE_PAT_GRP1 && opc_reg[1:0] == 2'b11) imm_reg <= sext8(q_byte_in);
          else imm_reg <= {8'h00, q_byte_in};
        end
        IDE_ST_IHI:   imm_reg <= {q_byte_in, imm_reg[7:0]};
        default:      imm_reg <= imm_reg;
      endcase
    end
  end

  // Segment override latch: consumed by the instruction that follows it
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      seg_ovr_reg     <= IDE_SEG_DATA;
      seg_ovr_vld_reg <= 1'b0;
    end else if (take && state_reg == IDE_ST_OPC && op_d == IDE_OP_SEG) begin
      seg_ovr_reg     <= q_byte_in[4:3];
      seg_ovr_vld_reg <= 1'b1;
    end else if (done) begin
      seg_ovr_vld_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Final decode, computed on the last byte
  // ----------------------------------------
  ide_decode_t fin;
  always_comb begin
    logic        one_byte;
    logic        mem;
    logic [15:0] disp;
    logic [7:0]  ob;
    one_byte = (state_reg == IDE_ST_OPC);
    ob       = one_byte ? q_byte_in : opc_reg;
    mem      = need_modrm && (mod_f != IDE_MOD_REG);
    disp     = disp_reg;
    fin      = '0;
    fin.op   = op_d;
    fin.word = ob[0];
    fin.reg_is_dst = ob[1];
    fin.mem_operand = mem;
    fin.reg_num     = xf;
    fin.rm_reg_num  = rm_f;
    // Fully formed displacement at the moment of completion
    if (state_reg == IDE_ST_DLO) disp = sext8(q_byte_in);
    else if (state_reg == IDE_ST_DHI) disp = {q_byte_in, disp_reg[7:0]};
    case (rm_f)
      3'h0: fin.eff_addr = addr_regs_in.base_word_reg + addr_regs_in.src_index_reg + disp;
      3'h1: fin.eff_addr = addr_regs_in.base_word_reg + addr_regs_in.dest_index_reg + disp;
      3'h2: fin.eff_addr = addr_regs_in.frame_base_reg + addr_regs_in.src_index_reg + disp;
      3'h3: fin.eff_addr = addr_regs_in.frame_base_reg + addr_regs_in.dest_index_reg + disp;
      3'h4: fin.eff_addr = addr_regs_in.src_index_reg + disp;
      3'h5: fin.eff_addr = addr_regs_in.dest_index_reg + disp;
      3'h6: fin.eff_addr = (mod_f == IDE_MOD_NODISP) ? disp
                           : addr_regs_in.frame_base_reg + disp;
      default: fin.eff_addr = addr_regs_in.base_word_reg + disp;
    endcase
    if (!mem) fin.eff_addr = 16'h0000;
    // Segment: string destination fixed, override next, frame defaults to stack
    if (string_dst_in) fin.seg_sel = IDE_SEG_EXTRA;
    else if (seg_ovr_vld_reg) fin.seg_sel = seg_ovr_reg;
    else if (mem && (rm_f == 3'h2 || rm_f == 3'h3 ||
             (rm_f == 3'h6 && mod_f != IDE_MOD_NODISP))) fin.seg_sel = IDE_SEG_STACK;
    else fin.seg_sel = IDE_SEG_DATA;
    if (state_reg == IDE_ST_ILO) fin.imm = (ob[7:2] == IDE_PAT_GRP1 && ob[1:0] == 2'b11)
                                           ? sext8(q_byte_in) : {8'h00, q_byte_in};
    else if (state_reg == IDE_ST_IHI) fin.imm = {q_byte_in, imm_reg[7:0]};
    else fin.imm = imm_reg;
    // Listed counts already include the address computation time
    fin.clk_min = IDE_CLK_RR;
    if (ob[7:2] == IDE_PAT_GRP1) begin
      if (xf == IDE_X_CMP) fin.clk_min = pick(mem, IDE_CLK_RR, IDE_CLK_RM_MEM);
      else fin.clk_min = pick(mem, IDE_CLK_IMM_REG, IDE_CLK_IMM_MEM);
      case (xf)
        IDE_X_ADD: fin.op = IDE_OP_ADD;
        IDE_X_ADC: fin.op = IDE_OP_ADC;
        IDE_X_SUB: fin.op = IDE_OP_SUB;
        IDE_X_SBB: fin.op = IDE_OP_SBB;
        IDE_X_CMP: fin.op = IDE_OP_CMP;
        default:   fin.op = IDE_OP_NONE;
      endcase
    end else if (ob[7:1] == IDE_PAT_GRP4) begin
      fin.clk_min = pick(mem, IDE_CLK_RR, IDE_CLK_INC_MEM);
      if (xf == IDE_X_ADD) fin.op = IDE_OP_INC;
      else if (xf == IDE_X_DEC) fin.op = IDE_OP_DEC;
      else fin.op = IDE_OP_NONE;
    end else if (ob[7:1] == IDE_PAT_GRP3) begin
      if (xf == IDE_X_NEG) begin
        fin.op = IDE_OP_NEG;
        fin.clk_min = pick(mem, IDE_CLK_RR, IDE_CLK_RM_MEM);
      end else if (xf == IDE_X_MUL) begin
        fin.op = IDE_OP_MUL;
        fin.clk_min = mem ? (ob[0] ? IDE_CLK_MUL_MW : IDE_CLK_MUL_MB)
                          : (ob[0] ? IDE_CLK_MUL_RW : IDE_CLK_MUL_RB);
      end else fin.op = IDE_OP_NONE;
    end else if (need_modrm) fin.clk_min = pick(mem, IDE_CLK_RR, IDE_CLK_RM_MEM);
    else if (need_imm) fin.clk_min = ob[0] ? IDE_CLK_ACC_W : IDE_CLK_RR;
    else begin
      case (op_d)
        IDE_OP_AAA: fin.clk_min = IDE_CLK_AAA;
        IDE_OP_AAS: fin.clk_min = IDE_CLK_AAS;
        IDE_OP_DAA, IDE_OP_DAS: fin.clk_min = IDE_CLK_DAX;
        default: fin.clk_min = IDE_CLK_RR;
      endcase
      fin.reg_num = ob[2:0];
      fin.word    = 1'b1;
    end
    // Queue handshake slack on memory forms; multiply carries its own span
    if (fin.op == IDE_OP_MUL) fin.clk_max = fin.clk_min + IDE_CLK_MUL_SPAN;
    else if (mem) fin.clk_max = fin.clk_min + IDE_CLK_MEM_SLIP;
    else fin.clk_max = fin.clk_min;
  end

  // ----------------------------------------
  // Outputs from flip-flops
  // ----------------------------------------
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dec_valid_out   <= 1'b0;
      dec_out         <= '0;
      dec_illegal_out <= 1'b0;
    end else begin
      dec_valid_out   <= done || (take && state_reg == IDE_ST_OPC && op_d == IDE_OP_SEG);
      dec_illegal_out <= take && state_reg == IDE_ST_OPC && illegal;
      if (done) dec_out <= fin;
      else if (take && state_reg == IDE_ST_OPC && op_d == IDE_OP_SEG) begin
        dec_out         <= '0;
        dec_out.op      <= IDE_OP_SEG;
        dec_out.seg_sel <= q_byte_in[4:3];
        dec_out.clk_min <= IDE_CLK_SEG;
        dec_out.clk_max <= IDE_CLK_SEG;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_seg_clk;
    @(posedge mclk_in) disable iff (!rst_b_in)
    dec_valid_out && dec_out.op == IDE_OP_SEG |-> dec_out.clk_min == 6'd2;
  endproperty
  a_seg_clk: assert property (p_seg_clk) else $error("prefix clocks wrong");

  property p_aaa;
    @(posedge mclk_in) disable iff (!rst_b_in)
    take && state_reg == IDE_ST_OPC && q_byte_in == 8'h37 |=> dec_valid_out && dec_out.clk_min == 6'd8;
  endproperty
  a_aaa: assert property (p_aaa) else $error("ascii adjust add wrong");

  property p_daa;
    @(posedge mclk_in) disable iff (!rst_b_in)
    take && state_reg == IDE_ST_OPC && (q_byte_in == 8'h27 || q_byte_in == 8'h2f)
    |=> dec_out.clk_min == 6'd4;
  endproperty
  a_daa: assert property (p_daa) else $error("decimal adjust wrong");

  property p_mul_span;
    @(posedge mclk_in) disable iff (!rst_b_in)
    dec_valid_out && dec_out.op == IDE_OP_MUL |-> dec_out.clk_max == dec_out.clk_min + 6'd2
      && dec_out.clk_min >= 6'd26;
  endproperty
  a_mul_span: assert property (p_mul_span) else $error("multiply span wrong");

  property p_reg_no_ea;
    @(posedge mclk_in) disable iff (!rst_b_in)
    take && state_reg == IDE_ST_MODRM && q_byte_in[7:6] == 2'b11 |-> state_next != IDE_ST_DLO;
  endproperty
  a_reg_no_ea: assert property (p_reg_no_ea) else $error("register form fetched disp");

  property p_disp8;
    @(posedge mclk_in) disable iff (!rst_b_in)
    take && state_reg == IDE_ST_DLO && modrm_reg[7:6] == 2'b01 |=> state_reg != IDE_ST_DHI
      && disp_reg == {{8{$past(q_byte_in[7])}}, $past(q_byte_in)};
  endproperty
  a_disp8: assert property (p_disp8) else $error("short displacement wrong");

  property p_disp16;
    @(posedge mclk_in) disable iff (!rst_b_in)
    take && state_reg == IDE_ST_DLO && modrm_reg[7:6] == 2'b10 |=> state_reg == IDE_ST_DHI;
  endproperty
  a_disp16: assert property (p_disp16) else $error("long displacement wrong");

  property p_imm_two;
    @(posedge mclk_in) disable iff (!rst_b_in)
    take && state_reg == IDE_ST_ILO && opc_reg[7:2] == 6'h20 |=>
      (state_reg == IDE_ST_IHI) == ($past(opc_reg[1:0]) == 2'b01);
  endproperty
  a_imm_two: assert property (p_imm_two) else $error("immediate length wrong");

  property p_string_seg;
    @(posedge mclk_in) disable iff (!rst_b_in)
    done && string_dst_in |=> dec_out.seg_sel == 2'h0;
  endproperty
  a_string_seg: assert property (p_string_seg) else $error("string segment wrong");

endmodule
`default_nettype wire

// *** common/ide_pkg.sv ***
// Package for the instruction decoder and effective-address generator
package ide_pkg;

  // ----------------------------------------
  // Operation classes
  // ----------------------------------------
  typedef enum logic [4:0] {
    IDE_OP_NONE = 5'h00,
    IDE_OP_ADD  = 5'h01,
    IDE_OP_ADC  = 5'h02,
    IDE_OP_SUB  = 5'h03,
    IDE_OP_SBB  = 5'h04,
    IDE_OP_INC  = 5'h05,
    IDE_OP_DEC  = 5'h06,
    IDE_OP_CMP  = 5'h07,
    IDE_OP_NEG  = 5'h08,
    IDE_OP_AAA  = 5'h09,
    IDE_OP_AAS  = 5'h0a,
    IDE_OP_DAA  = 5'h0b,
    IDE_OP_DAS  = 5'h0c,
    IDE_OP_MUL  = 5'h0d,
    IDE_OP_SEG  = 5'h0e
  } ide_op_t;

  typedef enum logic [2:0] {
    IDE_ST_OPC  = 3'b000,
    IDE_ST_MODRM = 3'b001,
    IDE_ST_DLO  = 3'b010,
    IDE_ST_DHI  = 3'b011,
    IDE_ST_ILO  = 3'b100,
    IDE_ST_IHI  = 3'b101
  } ide_state_t;

  // ----------------------------------------
  // Decoded instruction record
  // ----------------------------------------
  typedef struct packed {
    ide_op_t     op;
    logic        word;
    logic        reg_is_dst;
    logic        mem_operand;
    logic [2:0]  reg_num;
    logic [2:0]  rm_reg_num;
    logic [15:0] eff_addr;
    logic [1:0]  seg_sel;
    logic [15:0] imm;
    logic [5:0]  clk_min;
    logic [5:0]  clk_max;
  } ide_decode_t;

  typedef struct packed {
    logic [15:0] base_word_reg;
    logic [15:0] frame_base_reg;
    logic [15:0] src_index_reg;
    logic [15:0] dest_index_reg;
  } ide_addr_regs_t;

  // ----------------------------------------
  // Opcode patterns and fields
  // ----------------------------------------
  localparam logic [5:0] IDE_PAT_ADD_RM = 6'h00;
  localparam logic [5:0] IDE_PAT_ADC_RM = 6'h04;
  localparam logic [5:0] IDE_PAT_SUB_RM = 6'h0a;
  localparam logic [5:0] IDE_PAT_SBB_RM = 6'h06;
  localparam logic [5:0] IDE_PAT_GRP1   = 6'h20;
  localparam logic [6:0] IDE_PAT_ADD_AI = 7'h02;
  localparam logic [6:0] IDE_PAT_ADC_AI = 7'h0a;
  localparam logic [6:0] IDE_PAT_SUB_AI = 7'h16;
  localparam logic [6:0] IDE_PAT_SBB_AI = 7'h0e;
  localparam logic [6:0] IDE_PAT_CMP_AI = 7'h1e;
  localparam logic [6:0] IDE_PAT_CMP_RR = 7'h1c;
  localparam logic [6:0] IDE_PAT_CMP_MR = 7'h1d;
  localparam logic [6:0] IDE_PAT_GRP4   = 7'h7f;
  localparam logic [6:0] IDE_PAT_GRP3   = 7'h7b;
  localparam logic [4:0] IDE_PAT_INC_R  = 5'h08;
  localparam logic [4:0] IDE_PAT_DEC_R  = 5'h09;
  localparam logic [7:0] IDE_OPC_AAA    = 8'h37;
  localparam logic [7:0] IDE_OPC_AAS    = 8'h3f;
  localparam logic [7:0] IDE_OPC_DAA    = 8'h27;
  localparam logic [7:0] IDE_OPC_DAS    = 8'h2f;
  localparam logic [2:0] IDE_SEG_HI     = 3'h1;
  localparam logic [2:0] IDE_SEG_LO     = 3'h6;

  localparam logic [2:0] IDE_X_ADD = 3'h0;
  localparam logic [2:0] IDE_X_DEC = 3'h1;
  localparam logic [2:0] IDE_X_ADC = 3'h2;
  localparam logic [2:0] IDE_X_SBB = 3'h3;
  localparam logic [2:0] IDE_X_NEG = 3'h3;
  localparam logic [2:0] IDE_X_MUL = 3'h4;
  localparam logic [2:0] IDE_X_SUB = 3'h5;
  localparam logic [2:0] IDE_X_CMP = 3'h7;

  localparam logic [1:0] IDE_MOD_NODISP = 2'h0;
  localparam logic [1:0] IDE_MOD_DISP8  = 2'h1;
  localparam logic [1:0] IDE_MOD_DISP16 = 2'h2;
  localparam logic [1:0] IDE_MOD_REG    = 2'h3;
  localparam logic [2:0] IDE_RM_DIRECT  = 3'h6;

  // Segment select codes: extra, code, stack, data
  localparam logic [1:0] IDE_SEG_EXTRA = 2'h0;
  localparam logic [1:0] IDE_SEG_CODE  = 2'h1;
  localparam logic [1:0] IDE_SEG_STACK = 2'h2;
  localparam logic [1:0] IDE_SEG_DATA  = 2'h3;

  // ----------------------------------------
  // Clock counts
  // ----------------------------------------
  localparam logic [5:0] IDE_CLK_SEG     = 6'd2;
  localparam logic [5:0] IDE_CLK_RR      = 6'd3;
  localparam logic [5:0] IDE_CLK_RM_MEM  = 6'd10;
  localparam logic [5:0] IDE_CLK_IMM_REG = 6'd4;
  localparam logic [5:0] IDE_CLK_IMM_MEM = 6'd16;
  localparam logic [5:0] IDE_CLK_ACC_W   = 6'd4;
  localparam logic [5:0] IDE_CLK_INC_MEM = 6'd15;
  localparam logic [5:0] IDE_CLK_AAA     = 6'd8;
  localparam logic [5:0] IDE_CLK_AAS     = 6'd7;
  localparam logic [5:0] IDE_CLK_DAX     = 6'd4;
  localparam logic [5:0] IDE_CLK_MUL_RB  = 6'd26;
  localparam logic [5:0] IDE_CLK_MUL_RW  = 6'd35;
  localparam logic [5:0] IDE_CLK_MUL_MB  = 6'd32;
  localparam logic [5:0] IDE_CLK_MUL_MW  = 6'd41;
  localparam logic [5:0] IDE_CLK_MUL_SPAN = 6'd2;
  localparam logic [5:0] IDE_CLK_MEM_SLIP = 6'd2;
  localparam logic [5:0] IDE_CLK_EA       = 6'd4;

endpackage

// *** verification/ide_queue_model.sv ***
// Prefetch queue model feeding instruction bytes to the decoder
`timescale 1ns/1ps
`default_nettype none
module ide_queue_model (
  input  wire logic       mclk_in,
  input  wire logic       rst_b_in,
  input  wire logic       q_ready_in,
  input  wire logic       stall_in,
  output logic            q_valid_out,
  output logic [7:0]      q_byte_out
);
  logic [7:0] fifo_q [$];
  task automatic push(input logic [7:0] b);
    fifo_q.push_back(b);
  endtask
  // An empty or stalled queue shows a changing byte, never a stale one
  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q_valid_out <= 1'b0;
      q_byte_out  <= 8'h00;
    end else begin
      if (q_valid_out && q_ready_in) void'(fifo_q.pop_front());
      q_valid_out <= fifo_q.size() > 0 && !stall_in;
      q_byte_out  <= (fifo_q.size() > 0 && !stall_in) ? fifo_q[0] : ~q_byte_out;
    end
  end
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench: random instruction streams through the decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ide_pkg::*;
  logic           mclk_in = 1'b0;
  logic           rst_b_in = 1'b0;
  logic           stall = 1'b0;
  logic           string_dst_in = 1'b0;
  ide_addr_regs_t addr_regs_in = '0;
  logic           q_valid, q_ready, dec_valid, dec_illegal;
  logic [7:0]     q_byte;
  ide_decode_t    dec;
  logic [15:0]    lfsr_reg = 16'h000e;
  int             num_errors = 0;
  int             checked = 0;
  ide_op_t        g1 [8] = '{IDE_OP_ADD, IDE_OP_NONE, IDE_OP_ADC, IDE_OP_SBB,
                             IDE_OP_NONE, IDE_OP_SUB, IDE_OP_NONE, IDE_OP_CMP};
  // Opcode in bits 10:3, second-byte field of the group opcodes in bits 2:0
  logic [10:0]    ops [$] = '{11'h1b8, 11'h1f8, 11'h138, 11'h178, 11'h130, 11'h170, 11'h1b0,
    11'h1f0, 11'h200, 11'h238, 11'h240, 11'h278, 11'h000, 11'h008, 11'h010, 11'h018, 11'h080,
    11'h098, 11'h140, 11'h158, 11'h0c0, 11'h0d0, 11'h1c0, 11'h1c8, 11'h1d0, 11'h1d8, 11'h020,
    11'h028, 11'h0a0, 11'h0a8, 11'h160, 11'h168, 11'h0e0, 11'h0e8, 11'h1e0, 11'h1e8, 11'h400,
    11'h40a, 11'h41b, 11'h405, 11'h40f, 11'h418, 11'h40d, 11'h407, 11'h7f0, 11'h7f9, 11'h7b3,
    11'h7bb, 11'h7b4, 11'h7bc, 11'h401};
  always #4 mclk_in = ~mclk_in;
  always @(posedge mclk_in) stall <= lfsr_reg[3] & lfsr_reg[0] & ~stall;
  ide_decoder i_ide_decoder (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .q_valid_in(q_valid),
    .q_byte_in(q_byte), .addr_regs_in(addr_regs_in), .string_dst_in(string_dst_in),
    .q_ready_out(q_ready), .dec_valid_out(dec_valid), .dec_out(dec),
    .dec_illegal_out(dec_illegal));
  ide_queue_model i_ide_queue_model (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .q_ready_in(q_ready), .stall_in(stall), .q_valid_out(q_valid), .q_byte_out(q_byte));
  function automatic logic [7:0] lfsr();
    lfsr_reg = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    return lfsr_reg[7:0];
  endfunction
  task automatic tally_and_finish();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bounded wait for a decode or illegal pulse
  task automatic wt(input logic ill);
    int n;
    n = 0;
    do begin
      @(posedge mclk_in);
      #1;
      n++;
      if (n > 50) begin
        num_errors++;
        tally_and_finish();
      end
    end while ((ill ? dec_illegal : dec_valid) !== 1'b1);
  endtask
  task automatic run(input logic [10:0] ox);
    logic [7:0]     o, m, b [6];
    logic [15:0]    ea, dp, im;
    logic [5:0]     cr, cm, cn;
    logic [1:0]     ni, nd, sg;
    logic           hm, mem, pf, dir;
    ide_op_t        op;
    ide_addr_regs_t ar;
    o = ox[10:3];
    for (int k = 0; k < 6; k++) b[k] = lfsr();
    for (int k = 0; k < 8; k++) ar = {ar[55:0], lfsr()};
    m = {b[0][7:6], o >= 8'h80 ? ox[2:0] : b[0][5:3], b[0][2:0]};
    {hm, ni, cr, cm} = {1'b1, 2'd0, 6'd3, 6'd10};
    case (o) inside
      8'h37: {op, hm, cr} = {IDE_OP_AAA, 1'b0, 6'd8};
      8'h3f: {op, hm, cr} = {IDE_OP_AAS, 1'b0, 6'd7};
      8'h27: {op, hm, cr} = {IDE_OP_DAA, 1'b0, 6'd4};
      8'h2f: {op, hm, cr} = {IDE_OP_DAS, 1'b0, 6'd4};
      8'h26, 8'h2e, 8'h36, 8'h3e: {op, hm, cr} = {IDE_OP_SEG, 1'b0, 6'd2};
      [8'h40:8'h47]: {op, hm} = {IDE_OP_INC, 1'b0};
      [8'h48:8'h4f]: {op, hm} = {IDE_OP_DEC, 1'b0};
      [8'h00:8'h03]: op = IDE_OP_ADD;
      [8'h10:8'h13]: op = IDE_OP_ADC;
      [8'h28:8'h2b]: op = IDE_OP_SUB;
      [8'h18:8'h1b]: op = IDE_OP_SBB;
      [8'h38:8'h3b]: op = IDE_OP_CMP;
      8'h04, 8'h05: {op, hm} = {IDE_OP_ADD, 1'b0};
      8'h14, 8'h15: {op, hm} = {IDE_OP_ADC, 1'b0};
      8'h2c, 8'h2d: {op, hm} = {IDE_OP_SUB, 1'b0};
      8'h1c, 8'h1d: {op, hm} = {IDE_OP_SBB, 1'b0};
      8'h3c, 8'h3d: {op, hm} = {IDE_OP_CMP, 1'b0};
      [8'h80:8'h83]: {op, cr, cm, ni} = {g1[ox[2:0]], 6'd4, 6'd16, 2'd1 + (o[1:0] == 2'h1)};
      8'hfe, 8'hff: {op, cm} = {ox[0] ? IDE_OP_DEC : IDE_OP_INC, 6'd15};
      default: {op, cr, cm} = {ox[2] ? IDE_OP_MUL : IDE_OP_NEG, o[0] ? 6'd35 : 6'd26,
                               o[0] ? 6'd41 : 6'd32};
    endcase
    if (op == IDE_OP_NEG || (op == IDE_OP_CMP && hm)) {cr, cm} = {6'd3, 6'd10};
    if (!hm && o < 8'h40 && o[2:1] == 2'h2) {ni, cr} = {2'd1 + o[0], 6'd3 + o[0]};
    mem = hm && m[7:6] != 2'h3;
    cn = mem ? cm : cr;
    dir = m[7:6] == 2'h0 && m[2:0] == 3'h6;
    nd = !hm ? 2'd0 : m[7:6] == 2'h0 ? {dir, 1'b0} : m[7:6] == 2'h3 ? 2'd0 : m[7:6];
    dp = m[7:6] == 2'h1 ? {{8{b[1][7]}}, b[1]} : m[7:6] == 2'h2 ? {b[2], b[1]} : 16'h0000;
    ea = m[2] ? (m[1] ? (m[0] ? ar.base_word_reg : ar.frame_base_reg) : 16'h0000)
              : (m[1] ? ar.frame_base_reg : ar.base_word_reg);
    if (!m[2] || !m[1]) ea = ea + (m[0] ? ar.dest_index_reg : ar.src_index_reg);
    ea = !mem ? 16'h0000 : dir ? {b[2], b[1]} : ea + dp;
    im = ni == 2'd2 ? {b[4], b[3]} : o[1:0] == 2'h3 ? {{8{b[3][7]}}, b[3]} : {8'h00, b[3]};
    pf = b[5][0] && hm;
    sg = b[5][3] ? IDE_SEG_EXTRA : pf ? b[5][2:1]
       : (m[2:1] == 2'h1 || (m[2:0] == 3'h6 && !dir)) ? IDE_SEG_STACK : IDE_SEG_DATA;
    @(posedge mclk_in);
    addr_regs_in <= ar;
    string_dst_in <= b[5][3];
    @(negedge mclk_in);
    if (pf) begin
      i_ide_queue_model.push({3'h1, b[5][2:1], 3'h6});
      wt(1'b0);
      chk("prefix", {IDE_OP_SEG, 6'd2, b[5][2:1]}, {dec.op, dec.clk_min, dec.seg_sel});
      @(negedge mclk_in);
    end
    i_ide_queue_model.push(o);
    if (hm) i_ide_queue_model.push(m);
    for (int k = 1; k <= nd; k++) i_ide_queue_model.push(b[k]);
    for (int k = 3; k < 3 + ni; k++) i_ide_queue_model.push(b[k]);
    wt(1'b0);
    chk("op_clk", {op, cn, cn + ((mem || op == IDE_OP_MUL) ? 6'd2 : 6'd0)},
        {dec.op, dec.clk_min, dec.clk_max});
    chk("eff_addr", ea, dec.eff_addr);
    if (mem) chk("seg_sel", sg, dec.seg_sel);
    if (ni != 0) chk("imm", im, dec.imm);
    if (hm && !mem) chk("rm_reg", m[2:0], dec.rm_reg_num);
    if (hm && o < 8'h40) chk("regs", {m[5:3], o[1:0], mem},
        {dec.reg_num, dec.reg_is_dst, dec.word, dec.mem_operand});
    if (!hm && o[7:4] == 4'h4) chk("inc_reg", o[2:0], dec.reg_num);
  endtask
  initial begin
    repeat (10) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    repeat (12) foreach (ops[i]) run(ops[i]);
    @(negedge mclk_in);
    i_ide_queue_model.push(8'h0f);
    wt(1'b1);
    chk("no_record", 1'b0, dec_valid);
    tally_and_finish();
  end
endmodule
`default_nettype wire
